// >>> dacc_pkg.sv
/*
 * Package for the DAC update, clear and alarm control block.
 * Assumes a single 10 MHz clock and synchronous active-low reset.
 */
package dacc_pkg;
	localparam int NUM_CH = 12;
	localparam int CODE_W = 12;
	localparam int NUM_AIN = 4;
	localparam int NUM_TEMP = 3;
	localparam int AIN_HYS_W = 7;
	localparam int TEMP_HYS_W = 5;
	localparam int CNT_W = 8;
	localparam logic [11:0] CODE_RESET = 12'h000;
	// Alarm source positions in the auto-clear source word
	localparam int SRC_AIN0 = 0;
	localparam int SRC_TEMP0 = 4;
	localparam int SRC_OVERTEMP = 10;
	localparam int NUM_SRC = 11;
	// Alarm status layout: 4 inputs, 3 upper, 3 lower, overtemp
	localparam int ST_AIN0 = 0;
	localparam int ST_UP0 = 4;
	localparam int ST_LO0 = 7;
	localparam int ST_OT = 10;
	localparam int NUM_ST = 11;
	// Packed field positions as printed for the thermal selector
	localparam int OVERTEMP_SRC_BIT = 2;
	localparam int ACLR_EN_LSB = 3;
	localparam int ACLR_EN_MSB = 14;
	// Die overtemperature threshold and fixed hysteresis, degrees C
	localparam logic [11:0] OVERTEMP_LIMIT = 12'h096;
	localparam logic [11:0] OVERTEMP_HYS = 12'h008;
	localparam logic [2:0] AIN_PERSIST_RESET = 3'h3;
	localparam logic [1:0] TEMP_PERSIST_RESET = 2'h2;

	typedef struct packed {
		logic wr;
		logic [3:0] ch;
		logic [11:0] code;
	} dacc_wr_s;

	typedef struct packed {
		logic valid;
		logic [11:0] result;
	} dacc_sample_s;

	// Count of consecutive samples for an input persistence code
	// Top code capped by the eight-bit sample counter
	function automatic logic [7:0] ain_persist_n(input logic [2:0] sel);
		case (sel)
			3'h0: ain_persist_n = 8'h01;
			3'h7: ain_persist_n = 8'h80;
			default: ain_persist_n = 8'h01 << (sel + 3'h1);
		endcase
	endfunction : ain_persist_n

	function automatic logic [7:0] temp_persist_n(input logic [1:0] sel);
		temp_persist_n = 8'h01 << sel;
	endfunction : temp_persist_n
endpackage : dacc_pkg

// >>> dacc_window_mon.sv
/*
 * One window monitor: persistence count to set, hysteresis to release.
 * Assumes samples arrive as one-cycle valid strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module dacc_window_mon
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire dacc_pkg::dacc_sample_s sample,
	input wire logic [11:0] hi_lim,
	input wire logic [11:0] lo_lim,
	input wire logic [11:0] hys,
	input wire logic [7:0] persist_n,
	output logic hi_cond,
	output logic lo_cond
);
	logic [7:0] hi_cnt_ff, nxt_hi_cnt;
	logic [7:0] lo_cnt_ff, nxt_lo_cnt;
	logic hi_ff, nxt_hi, lo_ff, nxt_lo;
	logic above, below, hi_back, lo_back;

	// Window compare; release points pulled inside by hysteresis
	always_comb
	begin
		above = sample.result > hi_lim;
		below = sample.result < lo_lim;
		hi_back = ({1'b0, sample.result} + {1'b0, hys}) <= {1'b0, hi_lim};
		lo_back = {1'b0, sample.result} >= ({1'b0, lo_lim} + {1'b0, hys});
		nxt_hi_cnt = hi_cnt_ff;
		nxt_lo_cnt = lo_cnt_ff;
		nxt_hi = hi_ff;
		nxt_lo = lo_ff;
		if (!enable)
		begin
			nxt_hi_cnt = 8'h00;
			nxt_lo_cnt = 8'h00;
			nxt_hi = 1'b0;
			nxt_lo = 1'b0;
		end
		else if (sample.valid)
		begin
			// Set only after N consecutive out-of-range samples
			nxt_hi_cnt = above ? ((hi_cnt_ff < persist_n) ? hi_cnt_ff + 8'h01 : hi_cnt_ff) : 8'h00;
			nxt_lo_cnt = below ? ((lo_cnt_ff < persist_n) ? lo_cnt_ff + 8'h01 : lo_cnt_ff) : 8'h00;
			if (above && nxt_hi_cnt >= persist_n)
				nxt_hi = 1'b1;
			else if (hi_back)
				nxt_hi = 1'b0;
			if (below && nxt_lo_cnt >= persist_n)
				nxt_lo = 1'b1;
			else if (lo_back)
				nxt_lo = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			hi_cnt_ff <= 8'h00;
			lo_cnt_ff <= 8'h00;
			hi_ff <= 1'b0;
			lo_ff <= 1'b0;
		end
		else
		begin
			hi_cnt_ff <= nxt_hi_cnt;
			lo_cnt_ff <= nxt_lo_cnt;
			hi_ff <= nxt_hi;
			lo_ff <= nxt_lo;
		end
	end

	assign hi_cond = hi_ff;
	assign lo_cond = lo_ff;
endmodule : dacc_window_mon
`default_nettype wire

// >>> dacc_channel.sv
/*
 * One double-buffered DAC channel: input register, latch, clear override.
 * Assumes write, load and clear controls are single-clock signals.
 */
`timescale 1ns/1ps
`default_nettype none
module dacc_channel
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr,
	input wire logic [11:0] wr_code,
	input wire logic sync_load_select,
	input wire logic load_pulse,
	input wire logic clear_active,
	input wire logic [11:0] clear_code,
	output logic [11:0] latch_code
);
	logic [11:0] in_ff, nxt_in, latch_ff, nxt_latch;
	logic dirty_ff, nxt_dirty, clr_ff, nxt_clr;

	// Latch update priority: clear, release, async write, global load
	always_comb
	begin
		nxt_in = wr ? wr_code : in_ff;
		nxt_clr = clear_active;
		nxt_latch = latch_ff;
		nxt_dirty = dirty_ff;
		if (wr && sync_load_select)
			nxt_dirty = 1'b1; // Written since last trigger
		if (clear_active)
			nxt_latch = clear_code; // Input register untouched
		else if (clr_ff)
			nxt_latch = (wr && !sync_load_select) ? wr_code : in_ff; // Restore; async write same cycle wins
		else if (wr && !sync_load_select)
			nxt_latch = wr_code; // Follows every write
		else if (load_pulse && sync_load_select && dirty_ff)
			nxt_latch = in_ff;
		if (load_pulse && sync_load_select && !(wr && sync_load_select))
			nxt_dirty = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			in_ff <= dacc_pkg::CODE_RESET;
			latch_ff <= dacc_pkg::CODE_RESET;
			dirty_ff <= 1'b0;
			clr_ff <= 1'b0;
		end
		else
		begin
			in_ff <= nxt_in;
			latch_ff <= nxt_latch;
			dirty_ff <= nxt_dirty;
			clr_ff <= nxt_clr;
		end
	end

	assign latch_code = latch_ff;
endmodule : dacc_channel
`default_nettype wire

// >>> dacc_top.sv
/*
 * Top of the DAC update, clear and alarm control block.
 * Assumes control bits come from a register front end as plain synchronous ports,
 * and converted samples arrive as one-cycle strobes from the converter logic.
 */
// Behaviour
// - Twelve channels, input register plus latch; read latch
// - Async mode copies write into latch immediately
// - Sync mode write changes input register only
// - Global trigger loads all sync channels together
// - Trigger reloads only channels written since last
// - Reset sets registers, latches, outputs to zero
// - Clear loads clear code, input register kept
// - Leaving clear reloads latch from input register
// - Two active-low clear pins, each with mask
// - Software clear bits force channels clear
// - Selected alarm events clear enabled channels
// - Over 150C sets overtemp flag; field positions
// - Overtemp inactive while local sensor powered down
// - Out-of-range sets bit; global flag ORs all
// - Latched bits clear on read after subsiding
// - Unlatched bits follow the condition
// - Alarm pin low while any unmasked status bit set
// - Analog inputs flag outside high/low window
// - Temperatures have separate upper and lower flags
// - Gain bit selects two or five times reference
// - Masked events set status, pin unaffected
// - Release needs hysteresis back inside threshold
// - Set needs N consecutive out-of-range samples
`timescale 1ns/1ps
`default_nettype none
module dacc_top
(
	input wire logic clk,
	input wire logic rst_n,
	input wire dacc_pkg::dacc_wr_s data_wr,
	input wire logic [3:0] read_ch,
	output logic [11:0] read_code,
	input wire logic [11:0] sync_load_select,
	input wire logic global_load_trigger,
	input wire logic [11:0] gain_sel,
	output logic [11:0] gain_x5,
	input wire logic [143:0] clear_codes,
	input wire logic hw_clear_in_a_n,
	input wire logic hw_clear_in_b_n,
	input wire logic [11:0] pin_clear_channel_mask_a,
	input wire logic [11:0] pin_clear_channel_mask_b,
	input wire logic [11:0] sw_clear,
	input wire logic [15:0] autoclear_source,
	input wire logic [15:0] autoclear_channel_enable,
	input wire logic [10:0] alarm_src_sel,
	output logic [143:0] dac_codes,
	input wire dacc_pkg::dacc_sample_s [3:0] ain_sample,
	input wire logic [47:0] ain_hi_lim,
	input wire logic [47:0] ain_lo_lim,
	input wire logic [27:0] ain_hys,
	input wire logic [2:0] input_persist_count,
	input wire dacc_pkg::dacc_sample_s [2:0] temp_sample,
	input wire logic [35:0] temp_hi_lim,
	input wire logic [35:0] temp_lo_lim,
	input wire logic [14:0] temp_hys,
	input wire logic [1:0] temp_persist_count,
	input wire dacc_pkg::dacc_sample_s die_temp,
	input wire logic local_temp_monitor_on,
	input wire logic fault_hold_disable,
	input wire logic [10:0] fault_pin_unmask,
	input wire logic status_read,
	output logic [10:0] fault_status,
	output logic [3:0] input_window_flag,
	output logic [2:0] temp_upper_flag,
	output logic [2:0] temp_lower_flag,
	output logic die_overtemp_flag,
	output logic global_fault_flag,
	output logic alarm_pin_o,
	output logic alarm_pin_oe
);
	logic [10:0] cond, status_ff, nxt_status;
	logic [10:0] src_evt;
	logic [11:0] ch_clear, latch_q [12];
	logic [11:0] read_ff, nxt_read, gain_ff, nxt_gain;
	logic load_ff, nxt_load, trig_d_ff, nxt_trig_d;
	logic gflag_ff, nxt_gflag, pin_ff, nxt_pin;
	logic [143:0] codes_ff, nxt_codes;
	logic [3:0] ain_hi, ain_lo;
	logic ot_cond;

	// Map a channel index onto its slot of a packed vector
	function automatic logic [11:0] slot12(input logic [143:0] v, input int i);
		slot12 = v[i*12 +: 12];
	endfunction : slot12

	// Analog input monitors; a crossed window releases only past the hysteresis
	genvar gi;
	generate
		for (gi = 0; gi < dacc_pkg::NUM_AIN; gi++)
		begin : g_ain
			dacc_window_mon u_mon (
				.clk(clk),
				.rst_n(rst_n),
				.enable(1'b1),
				.sample(ain_sample[gi]),
				.hi_lim(ain_hi_lim[gi*12 +: 12]),
				.lo_lim(ain_lo_lim[gi*12 +: 12]),
				.hys({5'h00, ain_hys[gi*7 +: 7]}),
				.persist_n(dacc_pkg::ain_persist_n(input_persist_count)),
				.hi_cond(ain_hi[gi]),
				.lo_cond(ain_lo[gi])
			);
			assign cond[dacc_pkg::ST_AIN0 + gi] = ain_hi[gi] | ain_lo[gi];
		end
		for (gi = 0; gi < dacc_pkg::NUM_TEMP; gi++)
		begin : g_temp
			dacc_window_mon u_mon (
				.clk(clk),
				.rst_n(rst_n),
				.enable(1'b1),
				.sample(temp_sample[gi]),
				.hi_lim(temp_hi_lim[gi*12 +: 12]),
				.lo_lim(temp_lo_lim[gi*12 +: 12]),
				.hys({7'h00, temp_hys[gi*5 +: 5]}),
				.persist_n(dacc_pkg::temp_persist_n(temp_persist_count)),
				.hi_cond(cond[dacc_pkg::ST_UP0 + gi]),
				.lo_cond(cond[dacc_pkg::ST_LO0 + gi])
			);
		end
		for (gi = 0; gi < dacc_pkg::NUM_CH; gi++)
		begin : g_ch
			dacc_channel u_ch (
				.clk(clk),
				.rst_n(rst_n),
				.wr(data_wr.wr && data_wr.ch == 4'(gi)),
				.wr_code(data_wr.code),
				.sync_load_select(sync_load_select[gi]),
				.load_pulse(load_ff),
				.clear_active(ch_clear[gi]),
				.clear_code(slot12(clear_codes, gi)),
				.latch_code(latch_q[gi])
			);
		end
	endgenerate

	// Die overtemp: fixed limit, fixed hysteresis, single sample; off with sensor
	dacc_window_mon u_ot (
		.clk(clk),
		.rst_n(rst_n),
		.enable(local_temp_monitor_on),
		.sample(die_temp),
		.hi_lim(dacc_pkg::OVERTEMP_LIMIT),
		.lo_lim(12'h000),
		.hys(dacc_pkg::OVERTEMP_HYS),
		.persist_n(8'h01),
		.hi_cond(ot_cond),
		.lo_cond()
	);
	assign cond[dacc_pkg::ST_OT] = ot_cond;

	// Clear sources per channel; registered status bits feed the auto-clear
	always_comb
	begin
		src_evt = status_ff & alarm_src_sel;
		src_evt[dacc_pkg::ST_OT] = status_ff[dacc_pkg::ST_OT]
			& autoclear_source[dacc_pkg::OVERTEMP_SRC_BIT]
			& local_temp_monitor_on;
		ch_clear = (hw_clear_in_a_n ? 12'h000 : pin_clear_channel_mask_a)
			| (hw_clear_in_b_n ? 12'h000 : pin_clear_channel_mask_b)
			| sw_clear
			| ((|src_evt) ? autoclear_channel_enable[dacc_pkg::ACLR_EN_MSB:dacc_pkg::ACLR_EN_LSB]
				: 12'h000);
	end

	// Status, global flag, pin, load pulse, output registers
	always_comb
	begin
		nxt_trig_d = global_load_trigger;
		nxt_load = global_load_trigger && !trig_d_ff; // One pulse per write of 1
		if (fault_hold_disable)
			nxt_status = cond;
		else if (status_read)
			nxt_status = cond; // Read clears; live conditions reassert
		else
			nxt_status = status_ff | cond;
		// Overtemp bit dropped while the sensor is off, even when latched
		nxt_status[dacc_pkg::ST_OT] = nxt_status[dacc_pkg::ST_OT] & local_temp_monitor_on;
		nxt_gflag = |nxt_status;
		nxt_pin = |(nxt_status & fault_pin_unmask); // Masked events skip the pin
		nxt_read = latch_q[read_ch < 4'hC ? read_ch : 4'h0]; // Latch, not input
		nxt_gain = gain_sel; // 1 selects five times reference
		nxt_codes = codes_ff;
		for (int i = 0; i < dacc_pkg::NUM_CH; i++)
			nxt_codes[i*12 +: 12] = latch_q[i];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			status_ff <= 11'h000;
			gflag_ff <= 1'b0;
			pin_ff <= 1'b0;
			load_ff <= 1'b0;
			trig_d_ff <= 1'b0;
			read_ff <= 12'h000;
			gain_ff <= 12'h000;
			codes_ff <= '0;
		end
		else
		begin
			status_ff <= nxt_status;
			gflag_ff <= nxt_gflag;
			pin_ff <= nxt_pin;
			load_ff <= nxt_load;
			trig_d_ff <= nxt_trig_d;
			read_ff <= nxt_read;
			gain_ff <= nxt_gain;
			codes_ff <= nxt_codes;
		end
	end

	assign read_code = read_ff;
	assign gain_x5 = gain_ff;
	assign dac_codes = codes_ff;
	assign fault_status = status_ff;
	assign input_window_flag = status_ff[3:0];
	assign temp_upper_flag = status_ff[6:4];
	assign temp_lower_flag = status_ff[9:7];
	assign die_overtemp_flag = status_ff[10];
	assign global_fault_flag = gflag_ff;
	// Open drain: drive low only while asserted
	assign alarm_pin_o = 1'b0;
	assign alarm_pin_oe = pin_ff;
endmodule : dacc_top
`default_nettype wire

// >>> dacc_assertions.sv
/*
 * Checker for the DAC update, clear and alarm block.
 * Assumes clear codes hold steady while a clear is active.
 */
`timescale 1ns/1ps
`default_nettype none
module dacc_checker
(
	input wire logic clk,
	input wire logic rst_n,
	input wire dacc_pkg::dacc_wr_s data_wr,
	input wire logic [11:0] sync_load_select,
	input wire logic global_load_trigger,
	input wire logic [143:0] clear_codes,
	input wire logic hw_clear_in_a_n,
	input wire logic hw_clear_in_b_n,
	input wire logic [11:0] pin_clear_channel_mask_a,
	input wire logic [11:0] sw_clear,
	input wire logic [15:0] autoclear_channel_enable,
	input wire logic fault_hold_disable,
	input wire logic status_read,
	input wire logic [143:0] dac_codes,
	input wire logic [10:0] fault_status,
	input wire logic global_fault_flag,
	input wire logic alarm_pin_o,
	input wire logic alarm_pin_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Channels 0 and 2 free of every clear source, conservative
	logic idle0;
	logic idle2;
	assign idle0 = hw_clear_in_a_n && hw_clear_in_b_n && !sw_clear[0] && !autoclear_channel_enable[3];
	assign idle2 = hw_clear_in_a_n && hw_clear_in_b_n && !sw_clear[2] && !autoclear_channel_enable[5];
	AST_RESET_ZERO: assert property (disable iff (1'b0) !rst_n |=> dac_codes == '0 && !alarm_pin_oe)
		else $error("outputs not zero after reset");
	AST_ASYNC_LOAD: assert property (data_wr.wr && data_wr.ch == 4'h0
		&& !sync_load_select[0] && idle0 ##1 idle0 && !data_wr.wr
		|=> dac_codes[11:0] == $past(data_wr.code, 2))
		else $error("async write did not reach output");
	AST_SYNC_HOLD: assert property ((sync_load_select[2] && idle2 && !global_load_trigger)[*4]
		|=> $stable(dac_codes[35:24]))
		else $error("sync channel moved without trigger");
	AST_PIN_CLEAR: assert property ((!hw_clear_in_a_n && pin_clear_channel_mask_a[0])[*3]
		|-> dac_codes[11:0] == clear_codes[11:0])
		else $error("pin clear code missing");
	AST_SW_CLEAR: assert property ($rose(sw_clear[5]) |-> ##[1:3] dac_codes[71:60] == clear_codes[71:60])
		else $error("software clear code missing");
	AST_HOLD_LATCHED: assert property ((!fault_hold_disable && !status_read)[*2] ##0 fault_status[0]
		|=> fault_status[0])
		else $error("latched status dropped without read");
	AST_GLOBAL_OR: assert property (global_fault_flag == |fault_status)
		else $error("global flag not OR of status");
	AST_PIN_FLAG: assert property (alarm_pin_oe |-> global_fault_flag && !alarm_pin_o)
		else $error("alarm pin active without flag");
	// Main scenarios reached
	cover property (global_load_trigger ##1 !global_load_trigger);
	cover property ($rose(alarm_pin_oe));
	cover property ($fell(sw_clear[5]));
endmodule : dacc_checker
bind dacc_top dacc_checker chk_u (.clk, .rst_n, .data_wr, .sync_load_select, .global_load_trigger, .clear_codes,
	.hw_clear_in_a_n, .hw_clear_in_b_n, .pin_clear_channel_mask_a, .sw_clear, .autoclear_channel_enable,
	.fault_hold_disable, .status_read, .dac_codes, .fault_status, .global_fault_flag, .alarm_pin_o, .alarm_pin_oe);
`default_nettype wire

// >>> dacc_host_model.sv
/*
 * Host model: writes channel data, pulses the load trigger and status read.
 * Assumes the caller lets an edge pass between calls.
 */
`timescale 1ns/1ps
`default_nettype none
module dacc_host_model
(
	input wire logic clk,
	output dacc_pkg::dacc_wr_s data_wr,
	output logic global_load_trigger,
	output logic status_read
);
	// Idle bus from time zero
	initial
	begin
		data_wr = '0;
		global_load_trigger = 1'b0;
		status_read = 1'b0;
	end
	// One write strobe for one edge
	task automatic wr(input logic [3:0] ch, input logic [11:0] code);
		@(posedge clk);
		data_wr <= '{wr: 1'b1, ch: ch, code: code};
		@(posedge clk);
		data_wr.wr <= 1'b0;
	endtask : wr
	// Trigger acts on its rising edge, so drop it again
	task automatic load();
		@(posedge clk);
		global_load_trigger <= 1'b1;
		@(posedge clk);
		global_load_trigger <= 1'b0;
	endtask : load
	task automatic rd_status();
		@(posedge clk);
		status_read <= 1'b1;
		@(posedge clk);
		status_read <= 1'b0;
	endtask : rd_status
endmodule : dacc_host_model
`default_nettype wire

// >>> dacc_top_tb_top.sv
/*
 * Testbench for the DAC update, clear and alarm block.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module dacc_top_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] read_ch = 4'h0;
	logic [11:0] sls = 12'h000;
	logic [11:0] gain = 12'h000;
	logic hwa_n = 1'b1;
	logic hwb_n = 1'b1;
	logic [11:0] mska = 12'h000;
	logic [11:0] mskb = 12'h000;
	logic [11:0] swc = 12'h000;
	logic [15:0] acsrc = 16'h0000;
	logic [15:0] acen = 16'h0000;
	logic [10:0] asel = 11'h000;
	logic [27:0] ahys = 28'h000_0000;
	logic [2:0] apc = 3'h0;
	logic lt_on = 1'b1;
	logic hold_dis = 1'b0;
	logic [10:0] unmask = 11'h7ff;
	dacc_pkg::dacc_sample_s [3:0] ain = '0;
	dacc_pkg::dacc_sample_s die = '0;
	dacc_pkg::dacc_wr_s data_wr;
	logic trig;
	logic st_rd;
	logic [11:0] read_code;
	logic [11:0] gain_x5;
	logic [143:0] dac_codes;
	logic [10:0] fault_status;
	logic gflag;
	logic ot_flag;
	logic pin_oe;
	dacc_pkg::dacc_sample_s [2:0] tmp = '0;
	logic [14:0] thys = 15'h0000;
	logic [1:0] tpc = 2'h0;
	logic [3:0] iwf;
	logic [2:0] t_up;
	logic [2:0] t_lo;
	logic pin_o;
	int n_errors = 0;
	int comparisons = 0;
	// Same clear code on every channel
	localparam logic [143:0] CLRC = {12{12'hc5a}};
	// Window 100h..800h on every input, high kept above low
	localparam logic [47:0] AHI = {4{12'h800}};
	localparam logic [47:0] ALO = {4{12'h100}};
	// Temperature window 10h..50h, high kept above low
	localparam logic [35:0] THI = {3{12'h050}};
	localparam logic [35:0] TLO = {3{12'h010}};
	always #50 clk = ~clk;
	dacc_host_model host_u (.clk(clk), .data_wr(data_wr), .global_load_trigger(trig), .status_read(st_rd));
	dacc_top dut_u (.clk(clk), .rst_n(rst_n), .data_wr(data_wr), .read_ch(read_ch), .read_code(read_code),
		.sync_load_select(sls), .global_load_trigger(trig), .gain_sel(gain), .gain_x5(gain_x5),
		.clear_codes(CLRC), .hw_clear_in_a_n(hwa_n), .hw_clear_in_b_n(hwb_n), .pin_clear_channel_mask_a(mska),
		.pin_clear_channel_mask_b(mskb), .sw_clear(swc), .autoclear_source(acsrc),
		.autoclear_channel_enable(acen), .alarm_src_sel(asel), .dac_codes(dac_codes), .ain_sample(ain),
		.ain_hi_lim(AHI), .ain_lo_lim(ALO), .ain_hys(ahys), .input_persist_count(apc), .temp_sample(tmp),
		.temp_hi_lim(THI), .temp_lo_lim(TLO), .temp_hys(thys), .temp_persist_count(tpc),
		.die_temp(die), .local_temp_monitor_on(lt_on), .fault_hold_disable(hold_dis),
		.fault_pin_unmask(unmask), .status_read(st_rd), .fault_status(fault_status), .input_window_flag(iwf),
		.temp_upper_flag(t_up), .temp_lower_flag(t_lo), .die_overtemp_flag(ot_flag), .global_fault_flag(gflag),
		.alarm_pin_o(pin_o), .alarm_pin_oe(pin_oe));
	task automatic chk(input logic [11:0] g, input logic [11:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Settle past the edge before sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic smp(input logic [11:0] v);
		@(posedge clk);
		ain[0] <= '{valid: 1'b1, result: v};
		@(posedge clk);
		ain[0].valid <= 1'b0;
		tick(4);
	endtask : smp
	task automatic t_async();
		@(posedge clk);
		gain <= 12'h0a5;
		read_ch <= 4'h5;
		host_u.wr(4'h0, 12'h5a5);
		host_u.wr(4'h5, 12'h123);
		tick(3);
		chk(dac_codes[11:0], 12'h5a5);
		chk(dac_codes[71:60], 12'h123);
		chk(read_code, 12'h123);
		chk(gain_x5, 12'h0a5);
		$display("async load test done");
	endtask : t_async
	task automatic t_sync();
		@(posedge clk);
		sls <= 12'h00c;
		host_u.wr(4'h2, 12'h222);
		host_u.wr(4'h3, 12'h333);
		tick(3);
		chk(dac_codes[35:24], 12'h000);
		host_u.load();
		tick(4);
		chk(dac_codes[35:24], 12'h222);
		chk(dac_codes[47:36], 12'h333);
		host_u.wr(4'h2, 12'h2bc);
		host_u.load();
		tick(4);
		chk(dac_codes[35:24], 12'h2bc);
		chk(dac_codes[47:36], 12'h333);
		$display("sync load test done");
	endtask : t_sync
	task automatic t_clear();
		@(posedge clk);
		mska <= 12'h001;
		mskb <= 12'h004;
		hwa_n <= 1'b0;
		host_u.wr(4'h0, 12'h0ee);
		tick(4);
		chk(dac_codes[11:0], 12'hc5a);
		chk(dac_codes[35:24], 12'h2bc);
		@(posedge clk);
		hwa_n <= 1'b1;
		hwb_n <= 1'b0;
		tick(5);
		chk(dac_codes[11:0], 12'h0ee);
		chk(dac_codes[35:24], 12'hc5a);
		@(posedge clk);
		hwb_n <= 1'b1;
		swc <= 12'h020;
		tick(5);
		chk(dac_codes[35:24], 12'h2bc);
		chk(dac_codes[71:60], 12'hc5a);
		@(posedge clk);
		swc <= 12'h000;
		tick(5);
		chk(dac_codes[71:60], 12'h123);
		$display("clear test done");
	endtask : t_clear
	task automatic t_alarm();
		@(posedge clk);
		unmask <= 11'h7fe;
		smp(12'h900);
		chk(12'(fault_status), 12'h001);
		chk(12'(iwf), 12'h001);
		chk(12'(gflag), 12'h001);
		chk(12'(pin_oe), 12'h000);
		@(posedge clk);
		unmask <= 11'h7ff;
		smp(12'h080);
		chk(12'(pin_oe), 12'h001);
		chk(12'(pin_o), 12'h000);
		smp(12'h400);
		chk(12'(fault_status), 12'h001);
		host_u.rd_status();
		tick(4);
		chk(12'(fault_status), 12'h000);
		chk(12'(pin_oe), 12'h000);
		@(posedge clk);
		hold_dis <= 1'b1;
		smp(12'hfff);
		chk(12'(fault_status), 12'h001);
		smp(12'h400);
		chk(12'(fault_status), 12'h000);
		$display("alarm test done");
	endtask : t_alarm
	task automatic tsmp(input logic [11:0] v);
		@(posedge clk);
		tmp[0] <= '{valid: 1'b1, result: v};
		@(posedge clk);
		tmp[0].valid <= 1'b0;
		tick(4);
	endtask : tsmp
	// Input persistence of four, temperature persistence of two, hysteresis of 8
	task automatic t_temp();
		@(posedge clk);
		tpc <= 2'h1;
		thys <= 15'h0008;
		apc <= 3'h1;
		repeat (3) smp(12'h900);
		chk(12'(iwf), 12'h000);
		smp(12'h900);
		chk(12'(iwf), 12'h001);
		smp(12'h400);
		tsmp(12'h060);
		chk(12'(t_up), 12'h000);
		tsmp(12'h060);
		chk(12'(t_up), 12'h001);
		chk(12'(t_lo), 12'h000);
		repeat (2) tsmp(12'h008);
		chk(12'(t_up), 12'h000);
		chk(12'(t_lo), 12'h001);
		tsmp(12'h014);
		chk(12'(t_lo), 12'h001);
		tsmp(12'h020);
		chk(12'(t_lo), 12'h000);
		$display("persistence and temperature test done");
	endtask : t_temp
	// Die at 160 degrees, auto-clear of channel 1
	task automatic t_overtemp(input logic on, input logic [11:0] e);
		@(posedge clk);
		acsrc <= 16'h0004;
		acen <= 16'h0010;
		lt_on <= on;
		die <= '{valid: 1'b1, result: 12'h0a0};
		@(posedge clk);
		die.valid <= 1'b0;
		tick(5);
		chk(12'(ot_flag), 12'(on));
		chk(dac_codes[23:12], e);
		$display("overtemp test done");
	endtask : t_overtemp
	task automatic complete_run();
		$display("compares %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	// Main sequence after a two-cycle reset
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		tick(1);
		chk(dac_codes[11:0], 12'h000);
		chk(read_code, 12'h000);
		t_async();
		t_sync();
		t_clear();
		t_alarm();
		t_temp();
		t_overtemp(1'b0, 12'h000);
		t_overtemp(1'b1, 12'hc5a);
		complete_run();
	end
	// Watchdog at 2000 cycles, well beyond the roughly 180 cycles needed
	initial
	begin
		#200000;
		n_errors++;
		complete_run();
	end
endmodule : dacc_top_tb_top
`default_nettype wire
